/* File: common/wgc_pkg.sv */
// Purpose: shared constants and types of the waveform generator control
// Assumes: byte address of a register is four times its index
// Notes:   widths follow the register map; no storage here
package wgc_pkg;
    localparam int          ADDR_W      = 16;
    // register indices
    localparam logic [15:0] IDX_CLK_SEL = 16'h060c;
    localparam logic [15:0] IDX_SRC_SEL = 16'h060d;
    localparam logic [15:0] IDX_RISE_DB = 16'h060e;
    localparam logic [15:0] IDX_FALL_DB = 16'h060f;
    localparam logic [15:0] IDX_CTRL    = 16'h0610;
    localparam logic [15:0] IDX_POL     = 16'h0611;
    localparam logic [15:0] IDX_STOP    = 16'h0612;
    localparam logic [15:0] IDX_FLT_EN  = 16'h0613;
    localparam logic [15:0] IDX_STEER   = 16'h0614;
    // field positions
    localparam int          EN_BIT      = 7;
    localparam int          LD_BIT      = 6;
    localparam int          IN_BIT      = 5;
    localparam int          STOP_BIT    = 7;
    localparam int          REN_BIT     = 6;
    localparam int          BD_LSB      = 4;
    localparam int          AC_LSB      = 2;
    localparam int          CS_BIT      = 0;
    localparam int          FRC_LSB     = 4;
    // reset values
    localparam logic [7:0]  RST_CTRL    = 8'h00;
    localparam logic [3:0]  RST_POL     = 4'h0;
    localparam logic [7:0]  RST_STOP    = 8'h05;
    localparam logic [7:0]  RST_FLT_EN  = 8'h00;
    localparam logic [7:0]  RST_STEER   = 8'h00;
    localparam logic [4:0]  RST_SRC     = 5'h00;
    localparam logic        RST_CS      = 1'b0;
    localparam logic [5:0]  RST_DB      = 6'h00;
    // highest defined data source code
    localparam logic [4:0]  SRC_LAST    = 5'h11;
    localparam int          SRC_N       = 18;
    // safe level codes
    localparam logic [1:0]  LVL_HIGH    = 2'h3;
    localparam logic [1:0]  LVL_LOW     = 2'h2;
    localparam logic [1:0]  LVL_OFF     = 2'h1;

    typedef enum logic [2:0] {
        MODE_ASTEER = 3'h0,
        MODE_SSTEER = 3'h1,
        MODE_FWD    = 3'h2,
        MODE_REV    = 3'h3,
        MODE_HALF   = 3'h4,
        MODE_PUSH   = 3'h5
    } wgc_mode_t;

    typedef enum logic [1:0] {
        ST_RUN  = 2'h0,
        ST_STOP = 2'h1,
        ST_WAIT = 2'h3
    } wgc_state_t;
endpackage

/* File: common/wgc_src_if.sv */
// Purpose: carries the selected data input between select and control
// Assumes: one clock domain
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
interface wgc_src_if;
    logic [4:0] code;
    logic       level;
    logic       rise;
    logic       fall;
    logic       valid;
    modport sel  (input code, output level, output rise, output fall,
                  output valid);
    modport user (output code, input level, input rise, input fall,
                  input valid);
endinterface
`default_nettype wire

/* File: verilog/wgc_src_select.sv */
// Purpose: picks the data input and finds its edges
// Assumes: source inputs synchronous to the clock
// Notes:   reserved codes read as a steady low
`timescale 1ns/1ns
`default_nettype none
module wgc_src_select (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    input  wire logic [wgc_pkg::SRC_N-1:0] src_in,
    wgc_src_if.sel                       sp
);
    logic prev_r;
    logic pick;

    assign sp.valid = (sp.code <= wgc_pkg::SRC_LAST);   // [R16]
    assign pick     = sp.valid ? src_in[sp.code] : 1'b0;   // [R16]
    assign sp.level = pick;
    assign sp.rise  = pick & ~prev_r;
    assign sp.fall  = ~pick & prev_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
        end else if (ce) begin
            prev_r <= pick;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/wgc_top.sv */
// Purpose: register file and output control of the waveform generator
// Assumes: APB master, fault inputs active low and synchronous
// Notes:   dead-band timing lives outside; counts leave on RISE/FALL_DELAY
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Function
// R01 - with auto-restart, hardware clears stop flag once no fault remains
// R02 - after flag clears, outputs stay stopped until next data rising edge
// R03 - software clear of stop flag ignored while a fault is present
// R04 - generator keeps running regardless of system clock while sources live
// R05 - fast oscillator held on when enabled, source valid, fast clock chosen
// R06 - software keeps pins input and module off while configuring
// R07 - enabling starts in stopped state, driving safe levels
// R08 - software starts outputs by auto-restart or clearing stop flag
// R09 - control bit 7 enables the generator, resets to 0
// R10 - load request moves delay counts at rise after first fall, self-clears
// R11 - load request cannot be set in the cycle that enables the module
// R12 - mode field bits 2:0 select steering, bridge, half or push-pull
// R13 - polarity register bit 5 reads the selected data input level
// R14 - four polarity bits invert their outputs, reset to 0
// R15 - clock select bit 0 picks fast internal oscillator or system clock
// R16 - five-bit source field picks data input, codes above 10001 reserved
// R17 - steered output carries data with polarity, else forced level
// R18 - steering register: forced levels 7:4, steer bits 3:0, reset 0
// R19 - without auto-restart stop persists until software clears flag
// R20 - enabled active-low fault inputs force safe levels at once
// R21 - reserved mode or source codes hold outputs at inactive level
module wgc_top (
    input  wire logic        REF_CLK,
    input  wire logic        RESET_N,
    input  wire logic        CLK_EN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [15:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [17:0] SRC_IN,
    input  wire logic [7:0]  FAULT_N,
    output logic      [3:0]  WAVE_OUT,
    output logic      [3:0]  WAVE_OE,
    output logic             FAST_OSC_SEL,
    output logic             FAST_OSC_KEEP,
    output logic      [5:0]  RISE_DELAY,
    output logic      [5:0]  FALL_DELAY
);
    function automatic logic [15:0] baddr(input logic [15:0] idx);
        baddr = {idx[13:0], 2'b00};
    endfunction

    // level driven while stopped; idle code follows the output's polarity
    function automatic logic safe_lvl(input logic [1:0] code,
                                      input logic       pol);
        safe_lvl = (code == wgc_pkg::LVL_HIGH) ? 1'b1 :
                   (code == wgc_pkg::LVL_LOW)  ? 1'b0 : pol;
    endfunction

    wgc_src_if src ();

    // registers
    logic        clk_sel_r;
    logic [4:0]  src_sel_r;
    logic [5:0]  rise_db_r;
    logic [5:0]  fall_db_r;
    logic        en_r;
    logic        ld_r;
    logic        ld_arm_r;
    logic [2:0]  mode_r;
    logic [3:0]  pol_r;
    logic        stop_r;
    logic        ren_r;
    logic [1:0]  lvl_bd_r;
    logic [1:0]  lvl_ac_r;
    logic [7:0]  flt_en_r;
    logic [7:0]  steer_r;
    logic [3:0]  steer_act_r;
    logic        phase_r;
    wgc_pkg::wgc_state_t st_r;
    wgc_pkg::wgc_state_t st_nxt;
    logic        stop_nxt;
    logic [31:0] rdata_nxt;

    // bus decode
    wire acc      = PSEL & PENABLE;
    wire acc_end  = acc & PREADY;
    wire wr       = acc_end & PWRITE;
    wire hit_clk  = (PADDR == baddr(wgc_pkg::IDX_CLK_SEL));
    wire hit_src  = (PADDR == baddr(wgc_pkg::IDX_SRC_SEL));
    wire hit_rdb  = (PADDR == baddr(wgc_pkg::IDX_RISE_DB));
    wire hit_fdb  = (PADDR == baddr(wgc_pkg::IDX_FALL_DB));
    wire hit_ctl  = (PADDR == baddr(wgc_pkg::IDX_CTRL));
    wire hit_pol  = (PADDR == baddr(wgc_pkg::IDX_POL));
    wire hit_stp  = (PADDR == baddr(wgc_pkg::IDX_STOP));
    wire hit_fen  = (PADDR == baddr(wgc_pkg::IDX_FLT_EN));
    wire hit_str  = (PADDR == baddr(wgc_pkg::IDX_STEER));
    wire hit_any  = hit_clk | hit_src | hit_rdb | hit_fdb | hit_ctl |
                    hit_pol | hit_stp | hit_fen | hit_str;
    wire wr_ctl   = wr & hit_ctl;
    wire wr_stp   = wr & hit_stp;

    // fault, stop flag and load request
    wire fault    = |(flt_en_r & ~FAULT_N);                     // [R20]
    wire en_on    = wr_ctl & PWDATA[wgc_pkg::EN_BIT] & ~en_r;
    wire stop_set = fault | en_on |
                    (wr_stp & PWDATA[wgc_pkg::STOP_BIT]);       // [R07]
    wire sw_clr   = wr_stp & ~PWDATA[wgc_pkg::STOP_BIT];
    wire stop_clr = ~fault & (sw_clr | ren_r);          // [R01] [R03] [R19]
    wire ld_xfer  = ld_r & ld_arm_r & src.rise;                 // [R10]
    wire mode_ok  = (mode_r <= wgc_pkg::MODE_PUSH);
    wire bad_cfg  = ~mode_ok | ~src.valid;                      // [R21]
    wire go       = en_r & ~bad_cfg & ~fault & ~stop_r &
                    (st_r == wgc_pkg::ST_RUN);                  // [R02]

    assign src.code = src_sel_r;

    wgc_src_select u_src (
        .clk    (REF_CLK),
        .rst_n  (RESET_N),
        .ce     (CLK_EN),
        .src_in (SRC_IN),
        .sp     (src)
    );

    // waveform per mode, bit order D C B A
    wire       d        = src.level;
    wire [3:0] steer_on = (mode_r == wgc_pkg::MODE_ASTEER) ?
                          steer_r[3:0] : steer_act_r;
    wire [3:0] w_steer  = (steer_on & ({4{d}} ^ pol_r)) |
                          (~steer_on & steer_r[7:4]);           // [R17]
    wire [3:0] w_half   = {~d, d, ~d, d} ^ pol_r;
    wire [3:0] w_push   = {d & ~phase_r, d & phase_r,
                           d & ~phase_r, d & phase_r} ^ pol_r;
    wire [3:0] w_fwd    = {d, 1'b0, 1'b0, 1'b1} ^ pol_r;
    wire [3:0] w_rev    = {1'b0, 1'b1, d, 1'b0} ^ pol_r;
    wire       is_steer = (mode_r == wgc_pkg::MODE_ASTEER) |
                          (mode_r == wgc_pkg::MODE_SSTEER);
    wire [3:0] w_run    = is_steer                          ? w_steer :
                          (mode_r == wgc_pkg::MODE_FWD)     ? w_fwd :
                          (mode_r == wgc_pkg::MODE_REV)     ? w_rev :
                          (mode_r == wgc_pkg::MODE_HALF)    ? w_half :
                          w_push;                               // [R12]
    wire [3:0] w_safe   = {safe_lvl(lvl_bd_r, pol_r[3]),
                           safe_lvl(lvl_ac_r, pol_r[2]),
                           safe_lvl(lvl_bd_r, pol_r[1]),
                           safe_lvl(lvl_ac_r, pol_r[0])};
    wire       off_bd   = (lvl_bd_r == wgc_pkg::LVL_OFF);
    wire       off_ac   = (lvl_ac_r == wgc_pkg::LVL_OFF);
    wire [3:0] oe_safe  = ~{off_bd, off_ac, off_bd, off_ac};
    // disabled or badly configured: outputs rest at the inactive level
    wire [3:0] out_nxt  = (~en_r | bad_cfg) ? pol_r :
                          go ? w_run : w_safe;           // [R14] [R20] [R21]
    wire [3:0] oe_nxt   = (~en_r | bad_cfg | go) ? 4'hf : oe_safe;

    // stop flag: a hardware set beats any clear in the same cycle
    always_comb begin
        stop_nxt = stop_r;
        if (stop_set) begin
            stop_nxt = 1'b1;
        end else if (stop_clr) begin
            stop_nxt = 1'b0;
        end
    end

    always_comb begin
        st_nxt = st_r;
        if (!en_r) begin
            st_nxt = wgc_pkg::ST_STOP;                          // [R07]
        end else begin
            case (st_r)
                wgc_pkg::ST_RUN: begin
                    if (stop_r | fault) st_nxt = wgc_pkg::ST_STOP;
                end
                wgc_pkg::ST_STOP: begin
                    if (!stop_r && !fault) st_nxt = wgc_pkg::ST_WAIT;
                end
                wgc_pkg::ST_WAIT: begin
                    if (stop_r | fault) begin
                        st_nxt = wgc_pkg::ST_STOP;
                    end else if (src.rise) begin
                        st_nxt = wgc_pkg::ST_RUN;               // [R02]
                    end
                end
                default: st_nxt = wgc_pkg::ST_STOP;
            endcase
        end
    end

    // read data mux; unmapped reads return zero with an error
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (1'b1)
            hit_clk: rdata_nxt[0]   = clk_sel_r;
            hit_src: rdata_nxt[4:0] = src_sel_r;
            hit_rdb: rdata_nxt[5:0] = rise_db_r;
            hit_fdb: rdata_nxt[5:0] = fall_db_r;
            hit_ctl: rdata_nxt[7:0] = {en_r, ld_r, 3'b000, mode_r};
            hit_pol: rdata_nxt[7:0] = {2'b00, src.level, 1'b0, pol_r}; // [R13]
            hit_stp: rdata_nxt[7:0] = {stop_r, ren_r, lvl_bd_r,
                                       lvl_ac_r, 2'b00};
            hit_fen: rdata_nxt[7:0] = flt_en_r;
            hit_str: rdata_nxt[7:0] = steer_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // bus answer: one wait state, then pready for one cycle
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (CLK_EN) begin
            PREADY  <= acc & ~PREADY;
            PRDATA  <= (acc & ~PREADY & ~PWRITE) ? rdata_nxt : 32'h0000_0000;
            PSLVERR <= acc & ~PREADY & ~hit_any;
        end
    end

    // software-written configuration
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            clk_sel_r <= wgc_pkg::RST_CS;
            src_sel_r <= wgc_pkg::RST_SRC;
            en_r      <= wgc_pkg::RST_CTRL[wgc_pkg::EN_BIT];
            mode_r    <= wgc_pkg::RST_CTRL[2:0];
            pol_r     <= wgc_pkg::RST_POL;
            ren_r     <= wgc_pkg::RST_STOP[wgc_pkg::REN_BIT];
            lvl_bd_r  <= wgc_pkg::RST_STOP[wgc_pkg::BD_LSB+:2];
            lvl_ac_r  <= wgc_pkg::RST_STOP[wgc_pkg::AC_LSB+:2];
            flt_en_r  <= wgc_pkg::RST_FLT_EN;
            steer_r   <= wgc_pkg::RST_STEER;
        end else if (CLK_EN) begin
            if (wr & hit_clk) clk_sel_r <= PWDATA[wgc_pkg::CS_BIT];  // [R15]
            if (wr & hit_src) src_sel_r <= PWDATA[4:0];          // [R16]
            if (wr_ctl) begin
                en_r   <= PWDATA[wgc_pkg::EN_BIT];               // [R09]
                mode_r <= PWDATA[2:0];                           // [R12]
            end
            if (wr & hit_pol) pol_r <= PWDATA[3:0];              // [R14]
            if (wr_stp) begin
                ren_r    <= PWDATA[wgc_pkg::REN_BIT];
                lvl_bd_r <= PWDATA[wgc_pkg::BD_LSB+:2];
                lvl_ac_r <= PWDATA[wgc_pkg::AC_LSB+:2];
            end
            if (wr & hit_fen) flt_en_r <= PWDATA[7:0];
            if (wr & hit_str) steer_r <= PWDATA[7:0];            // [R18]
        end
    end

    // delay counts: direct while disabled, via load request while enabled
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rise_db_r  <= wgc_pkg::RST_DB;
            fall_db_r  <= wgc_pkg::RST_DB;
            RISE_DELAY <= wgc_pkg::RST_DB;
            FALL_DELAY <= wgc_pkg::RST_DB;
        end else if (CLK_EN) begin
            if (wr & hit_rdb) rise_db_r <= PWDATA[5:0];
            if (wr & hit_fdb) fall_db_r <= PWDATA[5:0];
            if (!en_r) begin
                if (wr & hit_rdb) RISE_DELAY <= PWDATA[5:0];
                if (wr & hit_fdb) FALL_DELAY <= PWDATA[5:0];
            end else if (ld_xfer) begin
                RISE_DELAY <= rise_db_r;                         // [R10]
                FALL_DELAY <= fall_db_r;
            end
        end
    end

    // load request: en_r is the old value, so enabling and setting
    // in one write leaves the request clear
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ld_r     <= wgc_pkg::RST_CTRL[wgc_pkg::LD_BIT];
            ld_arm_r <= 1'b0;
        end else if (CLK_EN) begin
            if (wr_ctl) begin
                ld_r     <= PWDATA[wgc_pkg::LD_BIT] & en_r
                            & PWDATA[wgc_pkg::EN_BIT];           // [R11]
                ld_arm_r <= 1'b0;
            end else if (!en_r || ld_xfer) begin
                ld_r     <= 1'b0;                                // [R10]
                ld_arm_r <= 1'b0;
            end else if (ld_r && src.fall) begin
                ld_arm_r <= 1'b1;
            end
        end
    end

    // run state, stop flag and waveform outputs
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r          <= wgc_pkg::ST_STOP;
            stop_r        <= wgc_pkg::RST_STOP[wgc_pkg::STOP_BIT];
            steer_act_r   <= wgc_pkg::RST_STEER[3:0];
            phase_r       <= 1'b0;
            WAVE_OUT      <= wgc_pkg::RST_POL;
            WAVE_OE       <= 4'hf;
            FAST_OSC_SEL  <= wgc_pkg::RST_CS;
            FAST_OSC_KEEP <= 1'b0;
        end else if (CLK_EN) begin
            st_r     <= st_nxt;
            stop_r   <= stop_nxt;                       // [R01] [R03] [R19]
            WAVE_OUT <= out_nxt;
            WAVE_OE  <= oe_nxt;
            // synchronous steering picks up new steer bits on a rising edge
            if (!en_r || src.rise) steer_act_r <= steer_r[3:0];
            if (!go) begin
                phase_r <= 1'b0;
            end else if (src.rise) begin
                phase_r <= ~phase_r;
            end
            // no sleep input: nothing here stops with the system clock
            FAST_OSC_SEL  <= clk_sel_r;                          // [R15]
            FAST_OSC_KEEP <= en_r & src.valid & clk_sel_r;  // [R04] [R05]
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_ld_ready;
        CLK_EN && en_r && ld_r && ld_arm_r && !wr_ctl;
    endsequence

    sequence s_ld_fire;
        s_ld_ready ##0 src.rise;
    endsequence

    chk_auto_restart: assert property (                          // [R01]
        (CLK_EN && ren_r && stop_r && !stop_set) |=> !stop_r)
        else $error("stop flag not cleared by auto-restart");
    chk_wait_edge: assert property (                             // [R02]
        (CLK_EN && en_r && st_r == wgc_pkg::ST_WAIT && !src.rise)
        |=> st_r != wgc_pkg::ST_RUN)
        else $error("run resumed without a data rising edge");
    chk_clear_blocked: assert property (                         // [R03]
        (CLK_EN && wr_stp && !PWDATA[wgc_pkg::STOP_BIT] && fault)
        |=> stop_r)
        else $error("stop flag cleared under fault");
    chk_enable_stop: assert property (                           // [R07]
        (CLK_EN && en_on) |=> (stop_r && st_r == wgc_pkg::ST_STOP))
        else $error("enable did not start stopped");
    chk_ld_enable: assert property (                             // [R11]
        (CLK_EN && !en_r && wr_ctl) |=> !ld_r)
        else $error("load request set while enabling");
    chk_ld_move: assert property (                               // [R10]
        s_ld_fire |=> (RISE_DELAY == $past(rise_db_r) && !ld_r))
        else $error("delay counts not moved on load edge");
    chk_fault_safe: assert property (                            // [R20]
        (CLK_EN && en_r && fault && !bad_cfg)
        |=> (WAVE_OUT == $past(w_safe) && WAVE_OE == $past(oe_safe)))
        else $error("fault did not force safe levels");
    chk_steer_force: assert property (                           // [R17]
        (CLK_EN && go && mode_r == wgc_pkg::MODE_ASTEER && !steer_r[1])
        |=> WAVE_OUT[1] == $past(steer_r[wgc_pkg::FRC_LSB+1]))
        else $error("unsteered output not at forced level");
    chk_reserved_idle: assert property (                         // [R21]
        (CLK_EN && en_r && bad_cfg) |=> WAVE_OUT == $past(pol_r))
        else $error("reserved code drove a waveform");
    chk_manual_hold: assert property (                           // [R19]
        (CLK_EN && !ren_r && stop_r && !wr_stp) |=> stop_r)
        else $error("stop flag dropped without software");
endmodule
`default_nettype wire

/* File: verif/wgc_power_stage.sv */
// Purpose: power switch stage model fed by the generator outputs
// Assumes: gate drivers pulled low while the generator is not driving
// Notes:   fault report is registered, held as long as trip stays high
`timescale 1ns/1ns
`default_nettype none
module wgc_power_stage (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       trip,
    input  wire logic [3:0] gate,
    input  wire logic [3:0] gate_oe,
    output logic            fault_n,
    output logic      [3:0] node
);
    // an undriven gate sinks to its pull-down, never keeps the last level
    assign node = gate & gate_oe;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_n <= 1'h1;
        end else begin
            fault_n <= ~trip;
        end
    end
endmodule
`default_nettype wire

/* File: verif/test_wgc_top.sv */
// Purpose: register level regression of the waveform generator control
// Assumes: byte address is index times four, one wait state per access
// Notes:   data source 0 is the only one toggled; others stay low
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin \
    miscompares++; $display("[ERR] %0t got %h exp %h", $time, g, x); \
end end
module test_wgc_top;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        psel = 1'h0;
    logic        pen = 1'h0;
    logic        pwr = 1'h0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic [17:0] src = 18'h0;
    logic        trip = 1'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, pf, fsel, fkeep, e;
    logic [3:0]  wout, woe;
    logic [5:0]  rdel, fdel;
    logic [7:0]  d;
    int          miscompares = 0;
    int          n_compared = 0;
    int          cyc = 0;
    always #25 clk = ~clk;
    wgc_top dut (.REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(1'h1),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SRC_IN(src), .FAULT_N({7'h7f, pf}),
        .WAVE_OUT(wout), .WAVE_OE(woe), .FAST_OSC_SEL(fsel),
        .FAST_OSC_KEEP(fkeep), .RISE_DELAY(rdel), .FALL_DELAY(fdel));
    wgc_power_stage stage (.clk(clk), .rst_n(rst_n), .trip(trip),
        .gate(wout), .gate_oe(woe), .fault_n(pf), .node());
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // request held until the edge that samples pready high
    task automatic bus(input logic w, input logic [15:0] i,
                       input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= {i[13:0], 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        d = prdata[7:0];
        e = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic wr(input logic [15:0] i, input logic [7:0] v);
        bus(1'h1, i, v);
    endtask
    task automatic rd(input logic [15:0] i, input logic [7:0] x);
        bus(1'h0, i, 8'h0);
        `CHK(d, x)
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // ceiling well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        tick(10);
        rst_n <= 1'h1;
        tick(1);
        rd(wgc_pkg::IDX_CTRL, 8'h00);
        rd(wgc_pkg::IDX_STEER, 8'h00);
        rd(wgc_pkg::IDX_POL, 8'h00);
        bus(1'h0, 16'h0615, 8'h0);
        `CHK(e, 1'h1)
        $display("test reset end");
        wr(wgc_pkg::IDX_CTRL, 8'h00);
        wr(wgc_pkg::IDX_POL, 8'h01);
        wr(wgc_pkg::IDX_SRC_SEL, 8'h00);
        wr(wgc_pkg::IDX_STEER, 8'h25);
        wr(wgc_pkg::IDX_STOP, 8'h38);
        wr(wgc_pkg::IDX_CLK_SEL, 8'h00);
        wr(wgc_pkg::IDX_CTRL, 8'h80);
        tick(3);
        `CHK({woe, wout}, 8'hfa)
        rd(wgc_pkg::IDX_STOP, 8'hb8);
        wr(wgc_pkg::IDX_STOP, 8'h38);
        tick(4);
        `CHK(wout, 4'ha)
        src[0] <= 1'h1;
        tick(4);
        `CHK(wout, 4'h6)
        rd(wgc_pkg::IDX_POL, 8'h21);
        src[0] <= 1'h0;
        tick(4);
        `CHK(wout, 4'h3)
        $display("test steer end");
        wr(wgc_pkg::IDX_FLT_EN, 8'h01);
        trip <= 1'h1;
        tick(3);
        `CHK(wout, 4'ha)
        wr(wgc_pkg::IDX_STOP, 8'h38);
        rd(wgc_pkg::IDX_STOP, 8'hb8);
        trip <= 1'h0;
        tick(3);
        rd(wgc_pkg::IDX_STOP, 8'hb8);
        // stop bit written 1 with restart on: auto-restart clears it once no fault remains
        wr(wgc_pkg::IDX_STOP, 8'hf8);
        tick(3);
        rd(wgc_pkg::IDX_STOP, 8'h78);
        `CHK(wout, 4'ha)
        src[0] <= 1'h1;
        tick(4);
        `CHK(wout, 4'h6)
        $display("test fault end");
        wr(wgc_pkg::IDX_RISE_DB, 8'h05);
        wr(wgc_pkg::IDX_FALL_DB, 8'h03);
        `CHK({rdel, fdel}, 12'h000)
        wr(wgc_pkg::IDX_CTRL, 8'hc0);
        src[0] <= 1'h0;
        tick(4);
        `CHK({rdel, fdel}, 12'h000)
        src[0] <= 1'h1;
        tick(4);
        `CHK({rdel, fdel}, 12'h143)
        rd(wgc_pkg::IDX_CTRL, 8'h80);
        wr(wgc_pkg::IDX_CTRL, 8'h00);
        wr(wgc_pkg::IDX_CTRL, 8'hc0);
        rd(wgc_pkg::IDX_CTRL, 8'h80);
        $display("test load end");
        wr(wgc_pkg::IDX_CLK_SEL, 8'h01);
        tick(2);
        `CHK({fsel, fkeep}, 2'h3)
        wr(wgc_pkg::IDX_SRC_SEL, 8'h12);
        tick(2);
        `CHK(fkeep, 1'h0)
        `CHK({woe, wout}, 8'hf1)
        for (int m = 0; m < 6; m++) begin
            wr(wgc_pkg::IDX_CTRL, 8'h80 | m[7:0]);
            rd(wgc_pkg::IDX_CTRL, 8'h80 | m[7:0]);
        end
        // half bridge on source 0: reselecting it gives the resume edge
        wr(wgc_pkg::IDX_CTRL, 8'h84);
        wr(wgc_pkg::IDX_SRC_SEL, 8'h00);
        tick(3);
        `CHK({woe, wout}, 8'hf4)
        $display("test mode end");
        stop_test();
    end
endmodule
`default_nettype wire
